/* File: core/adc_control_registers.v */
// Converter control registers with APB slave, acquisition and conversion sequencing.
// Assumes an APB master on sys_clk and a converter core that returns its result after
// the conversion clock periods that this block counts.
// Functional notes
// - Each conversion yields a ten-bit result.
// - Channel count is eleven, fifteen or sixteen by package variant.
// - Calibration bit set makes the next conversion a calibration.
// - Four-bit channel field selects input zero to fifteen.
// - Unimplemented channel gives an undefined result.
// - Start bit reads one while converting; software writes one to start.
// - Enable bit turns the converter on or off.
// - Unimplemented control bits read as zero.
// - Negative reference from input two when set, else analogue ground.
// - Positive reference from input three when set, else analogue supply.
// - Nonzero port field k makes inputs 15-k through 15 digital; field zero leaves every input analogue.
// - Format bit chooses right or left justification of the result.
// - Acquisition codes give 0,2,4,6,8,12,16,20 clock periods.
// - Clock code divides the oscillator or picks the RC oscillator.
// - RC clock starts after one instruction cycle delay.
// - All implemented control bits reset to zero.
// - Conversion end loads result, clears start, sets complete flag.
// - Nonzero acquisition samples for the programmed periods, then converts.
// - A conversion takes eleven conversion clock periods.
// - Reset turns the module off and aborts a conversion.
`include "adc_ctrl_map.vh"

module adc_control_registers #(
  parameter CHANNELS = 16
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        rc_tick,
  input  wire [9:0]  core_result,
  output reg         sample_enable,
  output reg         convert_active,
  output reg         calibrate,
  output reg  [3:0]  channel_select,
  output reg  [15:0] analog_input_mask,
  output reg         neg_ref_select,
  output reg         pos_ref_select,
  output reg         module_enable,
  output reg         conversion_complete_flag
);

  localparam ST_IDLE    = 2'h0;
  localparam ST_ACQUIRE = 2'h1;
  localparam ST_CONVERT = 2'h2;

  // Register selects from the address decoder; SEL_NONE reads zero and ignores writes.
  localparam SEL_NONE   = 3'h0;
  localparam SEL_MAIN   = 3'h1;
  localparam SEL_REF    = 3'h2;
  localparam SEL_TIMING = 3'h3;
  localparam SEL_RES_HI = 3'h4;
  localparam SEL_RES_LO = 3'h5;
  localparam SEL_STATUS = 3'h6;

  reg  [7:0]  ctrl_main_reg;
  reg  [7:0]  ref_port_reg;
  reg  [7:0]  timing_reg;
  reg  [15:0] result_reg;
  reg  [1:0]  state_reg;
  reg  [4:0]  period_cnt_reg;
  reg         cal_pending_reg;
  wire        period_tick;
  wire        wr_en;
  wire        rd_en;
  wire        busy;
  wire [4:0]  acq_periods;
  wire [2:0]  reg_sel;
  wire [15:0] mask_next;

  // Registers answer in the first access cycle; no wait states. Read data is captured
  // in the setup cycle, so it already stands when the access cycle samples it.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign busy    = state_reg != ST_IDLE;

  // Maps a bus address to a register select; shared by the write and read paths.
  function [2:0] decode_reg;
    input [11:0] addr;
    begin
      if (addr == `ADDR_CTRL_MAIN)
        decode_reg = SEL_MAIN;
      else if (addr == `ADDR_REF_PORT)
        decode_reg = SEL_REF;
      else if (addr == `ADDR_TIMING_FMT)
        decode_reg = SEL_TIMING;
      else if (addr == `ADDR_RESULT_HIGH)
        decode_reg = SEL_RES_HI;
      else if (addr == `ADDR_RESULT_LOW)
        decode_reg = SEL_RES_LO;
      else if (addr == `ADDR_STATUS)
        decode_reg = SEL_STATUS;
      else
        decode_reg = SEL_NONE;
    end
  endfunction
  assign reg_sel = decode_reg(paddr);

  // Maps an acquisition code to its period count.
  function [4:0] acq_count;
    input [2:0] code;
    begin
      case (code)
        3'h7:    acq_count = 5'h14;
        3'h6:    acq_count = 5'h10;
        3'h5:    acq_count = 5'h0c;
        3'h4:    acq_count = 5'h08;
        3'h3:    acq_count = 5'h06;
        3'h2:    acq_count = 5'h04;
        3'h1:    acq_count = 5'h02;
        default: acq_count = 5'h00;
      endcase
    end
  endfunction

  assign acq_periods = acq_count(timing_reg[`ACQ_HI:`ACQ_LO]);

  // one pin of the split
  // A pin is analogue when the field is zero or its number plus the field is below 15.
  // Pins beyond the package's channel count are never reported as analogue.
  function pin_analog;
    input integer pin;
    input [3:0]   code;
    begin
      if (pin >= CHANNELS)
        pin_analog = 1'b0;
      else if (code == 4'h0)
        pin_analog = 1'b1;
      else
        pin_analog = (pin + code) < 15;
    end
  endfunction

  // channel count limit
  // One decode per input pin; the output process registers the whole vector.
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pin
      assign mask_next[g] = pin_analog(g, ref_port_reg[`PORT_HI:`PORT_LO]);
    end
  endgenerate

  conv_clock_gen u_clk (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .run         (busy),
    .clk_select  (timing_reg[`CLK_HI:`CLK_LO]),
    .rc_tick     (rc_tick),
    .period_tick (period_tick)
  );

  // Register writes and the conversion sequence share one process, so the start
  // bit is never driven from two places.
  always @(posedge sys_clk) begin
    if (srst) begin
      ctrl_main_reg   <= `RESET_CTRL;
      ref_port_reg    <= `RESET_CTRL;
      timing_reg      <= `RESET_CTRL;
      // The result pair is cleared too, so a read before any conversion is defined.
      result_reg      <= 16'h0000;
      state_reg       <= ST_IDLE;
      period_cnt_reg  <= 5'h00;
      cal_pending_reg <= 1'b0;
      conversion_complete_flag <= 1'b0;
    end else begin
      if (wr_en) begin
        if (reg_sel == SEL_MAIN) begin
          ctrl_main_reg <= pwdata[7:0] & `MASK_CTRL_MAIN;
          // write one starts
          // While busy, a write can drop the start bit only by clearing the enable.
          if (busy || !pwdata[`ENABLE_BIT])
            ctrl_main_reg[`START_BIT] <= busy & pwdata[`ENABLE_BIT];
        end else if (reg_sel == SEL_REF) begin
          ref_port_reg <= pwdata[7:0] & `MASK_REF_PORT;
        end else if (reg_sel == SEL_TIMING) begin
          timing_reg <= pwdata[7:0] & `MASK_TIMING_FMT;
        end else if (reg_sel == SEL_STATUS && pwdata[0]) begin
          conversion_complete_flag <= 1'b0;
        end
      end
      case (state_reg)
        ST_IDLE: begin
          // Parked at zero so both phases count from their first tick.
          period_cnt_reg <= 5'h00;
          if (ctrl_main_reg[`START_BIT] && ctrl_main_reg[`ENABLE_BIT]) begin
            cal_pending_reg <= ctrl_main_reg[`CAL_BIT];
            state_reg <= (acq_periods == 5'h00) ? ST_CONVERT : ST_ACQUIRE;
          end
        end
        ST_ACQUIRE: begin
          // The divider keeps running across the hand-over, so no period is lost.
          if (period_tick) begin
            if (period_cnt_reg == acq_periods - 5'h01) begin
              period_cnt_reg <= 5'h00;
              state_reg      <= ST_CONVERT;
            end else begin
              period_cnt_reg <= period_cnt_reg + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (period_tick) begin
            if (period_cnt_reg == `CONV_PERIODS - 5'h01) begin
              state_reg       <= ST_IDLE;
              period_cnt_reg  <= 5'h00;
              cal_pending_reg <= 1'b0;
              ctrl_main_reg[`START_BIT] <= 1'b0;
              conversion_complete_flag  <= 1'b1;
              // any value accepted
              // The core still drives its result on this last period's edge.
              if (timing_reg[`JUSTIFY_BIT])
                result_reg <= {6'h00, core_result};
              else
                result_reg <= {core_result, 6'h00};
            end else begin
              period_cnt_reg <= period_cnt_reg + 5'h01;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // disable aborts
      // Placed last so a cleared enable wins over the state and start-bit steps of the sequence.
      if (!ctrl_main_reg[`ENABLE_BIT] && busy) begin
        state_reg <= ST_IDLE;
        ctrl_main_reg[`START_BIT] <= 1'b0;
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      if (reg_sel == SEL_MAIN)
        prdata <= {24'h000000, ctrl_main_reg};
      else if (reg_sel == SEL_REF)
        prdata <= {24'h000000, ref_port_reg};
      else if (reg_sel == SEL_TIMING)
        prdata <= {24'h000000, timing_reg};
      else if (reg_sel == SEL_RES_HI)
        prdata <= {24'h000000, result_reg[15:8]};
      else if (reg_sel == SEL_RES_LO)
        prdata <= {24'h000000, result_reg[7:0]};
      else if (reg_sel == SEL_STATUS)
        prdata <= {31'h00000000, conversion_complete_flag};
      else
        prdata <= 32'h00000000;
    end
  end

  // Drives to the analogue side; registered from the control bits.
  always @(posedge sys_clk) begin
    if (srst) begin
      sample_enable     <= 1'b0;
      convert_active    <= 1'b0;
      calibrate         <= 1'b0;
      channel_select    <= 4'h0;
      neg_ref_select    <= 1'b0;
      pos_ref_select    <= 1'b0;
      module_enable     <= 1'b0;
      analog_input_mask <= 16'h0000;
    end else begin
      module_enable  <= ctrl_main_reg[`ENABLE_BIT];
      channel_select <= ctrl_main_reg[`CHAN_HI:`CHAN_LO];
      sample_enable  <= ctrl_main_reg[`ENABLE_BIT] && state_reg != ST_CONVERT;
      convert_active <= state_reg == ST_CONVERT;
      calibrate      <= cal_pending_reg && state_reg == ST_CONVERT;
      neg_ref_select <= ref_port_reg[`NEG_REF_BIT];
      pos_ref_select <= ref_port_reg[`POS_REF_BIT];
      analog_input_mask <= mask_next;
    end
  end

endmodule // adc_control_registers

/* File: core/adc_ctrl_map.vh */
// Register offsets, field positions, reset values and timing counts for the converter control.
// Assumes inclusion by core files only; definitions, no logic.
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// Byte addresses on the APB side.
`define ADDR_CTRL_MAIN   12'h000
`define ADDR_REF_PORT    12'h004
`define ADDR_TIMING_FMT  12'h008
`define ADDR_RESULT_HIGH 12'h00c
`define ADDR_RESULT_LOW  12'h010
`define ADDR_STATUS      12'h014

// Field positions of the main control register.
`define CAL_BIT          7
`define CHAN_HI          5
`define CHAN_LO          2
`define START_BIT        1
`define ENABLE_BIT       0
// Field positions of the reference and port register.
`define NEG_REF_BIT      5
`define POS_REF_BIT      4
`define PORT_HI          3
`define PORT_LO          0
// Field positions of the timing and format register.
`define JUSTIFY_BIT      7
`define ACQ_HI           5
`define ACQ_LO           3
`define CLK_HI           2
`define CLK_LO           0

// Writable masks; unimplemented bits stay zero.
`define MASK_CTRL_MAIN   8'hbf
`define MASK_REF_PORT    8'h3f
`define MASK_TIMING_FMT  8'hbf
`define RESET_CTRL       8'h00

// Conversion length in clock periods, and the RC start delay in system clocks.
`define CONV_PERIODS     5'h0b
`define RC_START_DELAY   8'h04
`endif

/* File: core/conv_clock_gen.v */
// Conversion clock tick generator: one pulse per conversion clock period.
// Assumes the RC oscillator arrives as a tick already synchronous to sys_clk.
`include "adc_ctrl_map.vh"

module conv_clock_gen (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       run,
  input  wire [2:0] clk_select,
  input  wire       rc_tick,
  output reg        period_tick
);

  reg [5:0] div_reg;
  reg [7:0] rc_wait_reg;
  reg [5:0] div_last;
  wire      use_rc;

  assign use_rc = clk_select[1] & clk_select[0];

  // Divider end count from the select code; 2,4,8,16,32,64 oscillator periods.
  always @* begin
    case (clk_select)
      3'h0:    div_last = 6'h01;
      3'h4:    div_last = 6'h03;
      3'h1:    div_last = 6'h07;
      3'h5:    div_last = 6'h0f;
      3'h2:    div_last = 6'h1f;
      default: div_last = 6'h3f;
    endcase
  end

  // Count periods; the RC source waits one instruction cycle before its first tick.
  always @(posedge sys_clk) begin
    if (srst || !run) begin
      div_reg     <= 6'h00;
      rc_wait_reg <= 8'h00;
      period_tick <= 1'b0;
    end else if (use_rc) begin
      if (rc_wait_reg != `RC_START_DELAY) begin
        rc_wait_reg <= rc_wait_reg + 8'h01;
        period_tick <= 1'b0;
      end else begin
        period_tick <= rc_tick;
      end
    end else if (div_reg >= div_last) begin
      div_reg     <= 6'h00;
      period_tick <= 1'b1;
    end else begin
      div_reg     <= div_reg + 6'h01;
      period_tick <= 1'b0;
    end
  end

endmodule // conv_clock_gen

/* File: verif/adc_core_model.sv */
// Behavioural converter core and free-running RC oscillator.
// Assumes it shares sys_clk with the control block and sees its convert_active and channel_select outputs.
module adc_core_model #(
  parameter RC_DIV = 6
) (
  input  wire        sys_clk,
  input  wire  [3:0] channel_select,
  input  wire        convert_active,
  output logic       rc_tick,
  output logic [9:0] core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int         rc_cnt = 0;
  logic [9:0] wander = 10'h155;
  // The RC oscillator never stops, so the block must tolerate any tick phase.
  always @(posedge sys_clk) begin
    rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
    wander <= wander + 10'h0b7;
  end
  assign rc_tick = (rc_cnt == 0);
  // ten-bit result
  // Outside a conversion the value wanders, so a late sample shows up.
  assign core_result = convert_active ? {6'h29, channel_select} : wander;
endmodule // adc_core_model

/* File: verif/adc_ctrl_asserts.sv */
// Concurrent checks on the converter control block, seen from its ports.
// Assumes the single clock sys_clk and the synchronous reset srst.
module adc_ctrl_asserts (
  input wire        sys_clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        sample_enable,
  input wire        convert_active,
  input wire [3:0]  channel_select,
  input wire [15:0] analog_input_mask,
  input wire        neg_ref_select,
  input wire        pos_ref_select,
  input wire        module_enable,
  input wire        conversion_complete_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire        wr_main = psel && penable && pwrite && paddr == 12'h000;
  wire        wr_ref  = psel && penable && pwrite && paddr == 12'h004;
  reg  [7:0]  main_q;
  reg  [7:0]  ref_q;
  reg  [10:0] run_cnt;
  wire [15:0] mask_exp = (ref_q[3:0] == 4'h0) ? 16'hffff : 16'hffff >> (ref_q[3:0] + 5'h01);
  // Track the last written fields and how long convert_active has been high.
  always @(posedge sys_clk) begin
    if (wr_main) main_q <= pwdata[7:0];
    if (wr_ref) ref_q <= pwdata[7:0];
    run_cnt <= convert_active ? run_cnt + 11'h001 : 11'h000;
  end
  ref_port_a: assert property (wr_ref |=> ##[0:1] (analog_input_mask == mask_exp
    && neg_ref_select == ref_q[5] && pos_ref_select == ref_q[4])) else $error("ref or port wrong");
  main_fields_a: assert property (wr_main |=> ##[0:1]
    (channel_select == main_q[5:2] && module_enable == main_q[0])) else $error("main fields wrong");
  stay_idle_a: assert property (wr_main && pwdata[1] && !pwdata[0] && !module_enable
    && !convert_active |=> !convert_active [*4]) else $error("start taken while disabled");
  conv_length_a: assert property ($fell(convert_active) && module_enable
    |-> run_cnt >= 11'd20) else $error("conversion too short");
  done_flag_a: assert property ($fell(convert_active) && module_enable
    |-> ##[0:1] conversion_complete_flag) else $error("complete flag missing");
  disable_abort_a: assert property ($fell(module_enable) |-> ##[0:1] !convert_active)
    else $error("conversion not aborted");
  reset_clear_a: assert property (disable iff (1'b0) srst |=> !module_enable
    && !convert_active && !conversion_complete_flag) else $error("reset state wrong");
  sample_gate_a: assert property (sample_enable |-> module_enable && !convert_active)
    else $error("sampling while busy");
endmodule // adc_ctrl_asserts

bind adc_control_registers adc_ctrl_asserts chk_i (.sys_clk, .srst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .sample_enable, .convert_active, .channel_select, .analog_input_mask,
  .neg_ref_select, .pos_ref_select, .module_enable, .conversion_complete_flag);

/* File: verif/tb_adc_control_registers.sv */
// Self-checking bench: APB register traffic, conversions on every clock code, aborts.
// Assumes the core model on the far side and a free-running RC tick of six clocks.
module tb_adc_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire         pready, pslverr, rc_tick, sample_enable, convert_active, calibrate;
  wire         neg_ref_select, pos_ref_select, module_enable, conversion_complete_flag;
  wire  [31:0] prdata;
  wire  [9:0]  core_result;
  wire  [3:0]  channel_select;
  wire  [15:0] analog_input_mask;
  int          fails = 0, total_checks = 0, cyc = 0, t0, n, d;
  int          div_t[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int          acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic [9:0]  res;
  logic [3:0]  ch;

  // Free-running clock and a cycle count for timing the conversions.
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  adc_control_registers #(.CHANNELS(16)) DUT (.sys_clk, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .rc_tick, .core_result, .sample_enable,
    .convert_active, .calibrate, .channel_select, .analog_input_mask, .neg_ref_select,
    .pos_ref_select, .module_enable, .conversion_complete_flag);
  adc_core_model #(.RC_DIV(6)) partner (.sys_clk, .channel_select, .convert_active,
    .rc_tick, .core_result);

  // One APB transfer; the request holds until pready is seen high.
  task xfer(input bit w, input [11:0] a, input [7:0] v);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rdchk(input [11:0] a, input [31:0] e);
    xfer(0, a, 8'h00);
    chk(rd, e);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run through the same closing task.
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 0;
    rdchk(12'h000, 0);
    rdchk(12'h004, 0);
    rdchk(12'h008, 0);
    xfer(1, 12'h000, 8'hfc);
    rdchk(12'h000, 8'hbc);
    xfer(1, 12'h004, 8'hff);
    rdchk(12'h004, 8'h3f);
    xfer(1, 12'h008, 8'hff);
    rdchk(12'h008, 8'hbf);
    rdchk(12'h01c, 0);
    chk(pslverr, 0);
    // Every port code, with both reference selects toggling alongside.
    for (int k = 0; k < 16; k++) begin
      xfer(1, 12'h004, {2'b00, k[0], k[1], k[3:0]});
      repeat (2) @(posedge sys_clk);
      chk({neg_ref_select, pos_ref_select, analog_input_mask},
        {k[0], k[1], (k == 0) ? 16'hffff : 16'hffff >> (k + 1)});
    end
    // Each clock code with a different acquisition code and both justifications.
    for (int i = 0; i < 8; i++) begin
      ch = 4'(i * 2 + i / 7);
      res = {6'h29, ch};
      d = (div_t[i] == 0) ? 6 : div_t[i];
      n = (acq_t[i] + 11) * d;
      xfer(1, 12'h008, {i[0], 1'b0, i[2:0], i[2:0]});
      xfer(1, 12'h000, {i == 3, 1'b0, ch, 2'b01});
      t0 = cyc;
      xfer(1, 12'h000, {i == 3, 1'b0, ch, 2'b11});
      rdchk(12'h000, {i == 3, 1'b0, ch, 2'b11});
      while (!convert_active && cyc < t0 + 2000) @(posedge sys_clk);
      chk({calibrate, sample_enable, channel_select}, {i == 3, 1'b0, ch});
      do xfer(0, 12'h000, 8'h00); while (rd[1] !== 1'b0 && cyc < t0 + 3000);
      t0 = cyc - t0;
      chk(t0 >= n - d && t0 <= n + 3 * d + 16, 1);
      rdchk(12'h014, 1);
      chk(sample_enable, 1);
      rdchk(12'h00c, i[0] ? res[9:8] : res[9:2]);
      rdchk(12'h010, i[0] ? res[7:0] : {res[1:0], 6'h0});
      xfer(1, 12'h014, 8'h01);
      rdchk(12'h014, 0);
    end
    // Clearing the enable in mid-conversion, then a start while disabled.
    xfer(1, 12'h008, 8'h06);
    xfer(1, 12'h000, 8'h01);
    xfer(1, 12'h000, 8'h03);
    xfer(1, 12'h000, 8'h00);
    rdchk(12'h000, 0);
    xfer(1, 12'h000, 8'h02);
    rdchk(12'h000, 0);
    // A reset in mid-conversion returns everything to zero.
    xfer(1, 12'h000, 8'h01);
    xfer(1, 12'h000, 8'h03);
    repeat (3) @(posedge sys_clk);
    chk(convert_active, 1);
    srst <= 1;
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    chk({module_enable, convert_active, conversion_complete_flag}, 0);
    rdchk(12'h008, 0);
    test_done;
  end
endmodule // tb_adc_control_registers
